/* File: core/i2cmc_brg.v */
// Baud rate generator: reloadable down counter behind a divide-by-two
// prescale. Assumes load and stop are single-cycle requests.
`timescale 1ns/1ps
`default_nettype none
`include "i2cmc_defs.vh"
module i2cmc_brg (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Control
   input wire load,
   input wire stop,
   input wire [7:0] reload,
   // Status
   output reg timeout,
   output reg running
);
   reg div_r;
   reg [7:0] cnt_r;
   wire tick;

   assign tick = running & (div_r == `I2CMC_DIV_LAST);

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_r <= 1'b0;
         cnt_r <= 8'h00;
         running <= 1'b0;
         timeout <= 1'b0;
      end else begin
         timeout <= 1'b0;
         if (load) begin
            cnt_r <= reload;
            running <= 1'b1;
            // First step one clock after load keeps a reload loop at 2*(reload+1)
            div_r <= `I2CMC_DIV_LAST;
         end else if (stop) begin
            running <= 1'b0;
            div_r <= 1'b0;
         end else if (tick) begin
            div_r <= 1'b0;
            if (cnt_r == 8'h00) begin
               // One-shot; caller reloads for the next half period
               running <= 1'b0;
               timeout <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 8'h01;
            end
         end else if (running) begin
            div_r <= ~div_r;
         end
      end
   end
endmodule // i2cmc_brg
`default_nettype wire

/* File: core/i2cmc_defs.vh */
// Register map, field positions, reset values and timing counts for the
// I2C master collision and baud rate generator block. Definitions only.
`ifndef I2CMC_DEFS_VH
`define I2CMC_DEFS_VH

// Byte addresses of the word-aligned registers
`define I2CMC_ADR_RELOAD 8'h00
`define I2CMC_ADR_BUF 8'h04
`define I2CMC_ADR_CTRL 8'h08
`define I2CMC_ADR_STAT 8'h0c
`define I2CMC_ADR_MASK 8'h10

// Control register fields
`define I2CMC_CTL_RSEN 0
`define I2CMC_CTL_PEN 1
`define I2CMC_CTL_SPI 2
`define I2CMC_CTL_EN 3
`define I2CMC_CTL_BUSY 7

// Status and mask register fields
`define I2CMC_ST_COLL 0
`define I2CMC_ST_STOP 1
`define I2CMC_ST_WCOL 2
`define I2CMC_ST_SPI 3

// Reset values
`define I2CMC_RST_RELOAD 8'h09
`define I2CMC_RST_BYTE 8'h00

// Prescale ahead of the counter: two clocks per count step, so one
// rollover is 2*(reload+1) clocks and a full line period is 4*(reload+1)
`define I2CMC_DIV_LAST 1'b1

// Half periods in one SPI byte
`define I2CMC_SPI_HALVES 5'd16

`endif

/* File: core/i2cmc_sync.v */
// Two-flop synchronisers for the three line inputs.
// Assumes asynchronous pins; only the second stage is read outside.
`timescale 1ns/1ps
`default_nettype none
module i2cmc_sync (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Raw pins
   input wire [2:0] pin_in,
   // Synchronised levels
   output reg [2:0] pin_sync
);
   reg [2:0] meta_r;

   // Idle lines float high, so reset to ones
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= 3'h7;
         pin_sync <= 3'h7;
      end else begin
         meta_r <= pin_in;
         pin_sync <= meta_r;
      end
   end
endmodule // i2cmc_sync
`default_nettype wire

/* File: core/i2cmc_top.v */
// I2C master Repeated Start / Stop sequencing with bus collision checks,
// shared baud rate generator and a small SPI master, on classic Wishbone.
// Assumes open-drain lines resolved outside; 8-bit registers in low bits.
`timescale 1ns/1ps
`default_nettype none
`include "i2cmc_defs.vh"
// Overview of operation
// - Repeated Start: SDA low when SCL rises is a collision.
// - Repeated Start: SCL falling before SDA is pulled low is a collision.
// - After SDA floats high, count one period, release SCL, sample SDA.
// - SDA high: count again; SDA falling early is no collision.
// - During the second count, SCL low before SDA driven is a collision.
// - Both high at timeout: drive SDA low, count, then drive SCL low.
// - Stop: SDA sampled low after its release and timeout is a collision.
// - Stop: SCL low after release, before SDA is released, is a collision.
// - Stop: SDA low, release SCL, on SCL high count, then sample SDA.
// - One generator times both I2C and SPI, loaded from the reload register.
// - A transfer buffer write starts the generator counting.
// - When the operation ends the generator stops, clock pin holds level.
// - Counter reloaded twice per line clock period, as the mode decides.
// - Line clock is clock over four times reload plus one.
// - A collision sets the collision flag and returns the port to idle.
// - A collision aborts the sequence, frees both lines, clears its enable.
module i2cmc_top (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // I2C clock line
   input wire scl_in,
   output wire scl_out,
   output wire scl_oe,
   // I2C data line
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   // SPI master pins
   output reg spi_sck,
   output reg spi_mosi,
   input wire spi_miso,
   // Interrupt
   output wire irq
);
   localparam [9:0] ST_IDLE = 10'h001;
   localparam [9:0] ST_RS_SDAHI = 10'h002;
   localparam [9:0] ST_RS_CNT1 = 10'h004;
   localparam [9:0] ST_RS_SCLHI = 10'h008;
   localparam [9:0] ST_RS_CNT2 = 10'h010;
   localparam [9:0] ST_RS_CNT3 = 10'h020;
   localparam [9:0] ST_SP_SDALO = 10'h040;
   localparam [9:0] ST_SP_SCLHI = 10'h080;
   localparam [9:0] ST_SP_CNT1 = 10'h100;
   localparam [9:0] ST_SP_CNT2 = 10'h200;

   // Intended high while sampled low
   function line_lost;
      input intend_high;
      input sampled;
      begin
         line_lost = intend_high & ~sampled;
      end
   endfunction

   reg [9:0] state_r;
   reg [7:0] reload_r;
   reg [7:0] buf_r;
   reg [7:0] shift_r;
   reg [4:0] halves_r;
   reg spi_act_r;
   reg rsen_r;
   reg pen_r;
   reg spi_mode_r;
   reg en_r;
   reg [3:0] stat_r;
   reg [3:0] mask_r;
   reg scl_low_r;
   reg sda_low_r;
   reg brg_load_r;
   reg brg_stop_r;
   reg [3:0] ev_set;
   reg coll;
   wire [2:0] pins_s;
   wire scl_s;
   wire sda_s;
   wire miso_s;
   wire brg_to;
   wire brg_run;
   wire req;
   wire wr;
   wire rd;
   wire busy;
   wire seq_busy;
   wire spi_reload;
   wire brg_load;

   i2cmc_sync u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .pin_in({spi_miso, sda_in, scl_in}),
      .pin_sync(pins_s)
   );
   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign miso_s = pins_s[2];

   i2cmc_brg u_brg (
      .clk(clk),
      .arst_n(arst_n),
      .load(brg_load),
      .stop(brg_stop_r),
      .reload(reload_r),
      .timeout(brg_to),
      .running(brg_run)
   );

   // Open drain: only ever pull low
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = scl_low_r;
   assign sda_oe = sda_low_r;

   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = req & wb_we_i & wb_sel_i[0];
   assign rd = req & ~wb_we_i;
   assign seq_busy = (state_r != ST_IDLE);
   assign busy = seq_busy | spi_act_r | brg_run;
   assign irq = |(stat_r & mask_r);
   // SPI reload bypasses the register stage so each half period is exact
   assign spi_reload = spi_act_r & brg_to & (halves_r != `I2CMC_SPI_HALVES - 5'd1);
   assign brg_load = brg_load_r | spi_reload;

   // Collision detection per sequence phase
   always @* begin
      coll = 1'b0;
      case (state_r)
         ST_RS_SCLHI: coll = scl_s & line_lost(1'b1, sda_s);
         // Early SDA fall is another master's start, so not checked
         ST_RS_CNT2: coll = ~sda_low_r & line_lost(1'b1, scl_s);
         ST_SP_CNT1: coll = line_lost(1'b1, scl_s);
         ST_SP_CNT2: coll = brg_to & line_lost(1'b1, sda_s);
         default: coll = 1'b0;
      endcase
   end

   // Sticky event sources for the status register
   always @* begin
      ev_set = 4'h0;
      ev_set[`I2CMC_ST_COLL] = coll;
      ev_set[`I2CMC_ST_STOP] = (state_r == ST_SP_CNT2) & brg_to & sda_s;
      ev_set[`I2CMC_ST_WCOL] = wr & (wb_adr_i == `I2CMC_ADR_BUF) & busy;
      ev_set[`I2CMC_ST_SPI] = spi_act_r & brg_to & (halves_r == `I2CMC_SPI_HALVES - 5'd1);
   end

   // Wishbone slave: ack one cycle after the request, read data registered
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         reload_r <= `I2CMC_RST_RELOAD;
         mask_r <= 4'h0;
         stat_r <= 4'h0;
      end else begin
         wb_ack_o <= req;
         if (rd) begin
            case (wb_adr_i)
               `I2CMC_ADR_RELOAD: wb_dat_o <= {24'h00_0000, reload_r};
               `I2CMC_ADR_BUF: wb_dat_o <= {24'h00_0000, buf_r};
               `I2CMC_ADR_CTRL: wb_dat_o <= {24'h00_0000, busy, 3'h0, en_r,
                                             spi_mode_r, pen_r, rsen_r};
               `I2CMC_ADR_STAT: wb_dat_o <= {28'h000_0000, stat_r};
               `I2CMC_ADR_MASK: wb_dat_o <= {28'h000_0000, mask_r};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
         if (wr && wb_adr_i == `I2CMC_ADR_RELOAD)
            reload_r <= wb_dat_i[7:0];
         if (wr && wb_adr_i == `I2CMC_ADR_MASK)
            mask_r <= wb_dat_i[3:0];
         // Read clears, a same-cycle event survives
         if (rd && wb_adr_i == `I2CMC_ADR_STAT)
            stat_r <= ev_set;
         else
            stat_r <= stat_r | ev_set;
      end
   end

   // Sequencer, line drivers and generator requests
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_IDLE;
         rsen_r <= 1'b0;
         pen_r <= 1'b0;
         spi_mode_r <= 1'b0;
         en_r <= 1'b0;
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
         brg_load_r <= 1'b0;
         brg_stop_r <= 1'b0;
      end else begin
         brg_load_r <= 1'b0;
         brg_stop_r <= 1'b0;
         if (wr && wb_adr_i == `I2CMC_ADR_CTRL && !busy) begin
            rsen_r <= wb_dat_i[`I2CMC_CTL_RSEN];
            pen_r <= wb_dat_i[`I2CMC_CTL_PEN];
            spi_mode_r <= wb_dat_i[`I2CMC_CTL_SPI];
            en_r <= wb_dat_i[`I2CMC_CTL_EN];
         end
         if (coll) begin
            state_r <= ST_IDLE;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            rsen_r <= 1'b0;
            pen_r <= 1'b0;
            brg_stop_r <= 1'b1;
         end else begin
            case (state_r)
               ST_IDLE: begin
                  if (en_r && !spi_mode_r && !spi_act_r && !brg_run) begin
                     if (rsen_r) begin
                        // Clock held low from the last byte, data let go
                        scl_low_r <= 1'b1;
                        sda_low_r <= 1'b0;
                        state_r <= ST_RS_SDAHI;
                     end else if (pen_r) begin
                        scl_low_r <= 1'b1;
                        sda_low_r <= 1'b1;
                        state_r <= ST_SP_SDALO;
                     end
                  end
               end
               ST_RS_SDAHI: begin
                  if (sda_s) begin
                     brg_load_r <= 1'b1;
                     state_r <= ST_RS_CNT1;
                  end
               end
               ST_RS_CNT1: begin
                  if (brg_to) begin
                     scl_low_r <= 1'b0;
                     state_r <= ST_RS_SCLHI;
                  end
               end
               ST_RS_SCLHI: begin
                  // Waits here while another device stretches the clock
                  if (scl_s) begin
                     brg_load_r <= 1'b1;
                     state_r <= ST_RS_CNT2;
                  end
               end
               ST_RS_CNT2: begin
                  if (brg_to || !sda_s) begin
                     sda_low_r <= 1'b1;
                     brg_load_r <= 1'b1;
                     brg_stop_r <= 1'b0;
                     state_r <= ST_RS_CNT3;
                  end
               end
               ST_RS_CNT3: begin
                  if (brg_to) begin
                     scl_low_r <= 1'b1;
                     rsen_r <= 1'b0;
                     state_r <= ST_IDLE;
                  end
               end
               ST_SP_SDALO: begin
                  if (!sda_s) begin
                     scl_low_r <= 1'b0;
                     state_r <= ST_SP_SCLHI;
                  end
               end
               ST_SP_SCLHI: begin
                  if (scl_s) begin
                     brg_load_r <= 1'b1;
                     state_r <= ST_SP_CNT1;
                  end
               end
               ST_SP_CNT1: begin
                  if (brg_to) begin
                     sda_low_r <= 1'b0;
                     brg_load_r <= 1'b1;
                     state_r <= ST_SP_CNT2;
                  end
               end
               ST_SP_CNT2: begin
                  if (brg_to) begin
                     pen_r <= 1'b0;
                     state_r <= ST_IDLE;
                  end
               end
               default: begin
                  state_r <= ST_IDLE;
                  scl_low_r <= 1'b0;
                  sda_low_r <= 1'b0;
               end
            endcase
         end
         // Buffer write kicks the generator in either mode
         if (wr && wb_adr_i == `I2CMC_ADR_BUF && !busy)
            brg_load_r <= 1'b1;
      end
   end

   // Transfer buffer and SPI shifter; mode 0, MSB first
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         buf_r <= `I2CMC_RST_BYTE;
         shift_r <= `I2CMC_RST_BYTE;
         halves_r <= 5'd0;
         spi_act_r <= 1'b0;
         spi_sck <= 1'b0;
         spi_mosi <= 1'b0;
      end else begin
         if (wr && wb_adr_i == `I2CMC_ADR_BUF && !busy) begin
            // Writes during any activity are dropped and flagged instead
            buf_r <= wb_dat_i[7:0];
            if (spi_mode_r && en_r) begin
               shift_r <= wb_dat_i[7:0];
               spi_mosi <= wb_dat_i[7];
               halves_r <= 5'd0;
               spi_act_r <= 1'b1;
            end
         end else if (spi_act_r && brg_to) begin
            spi_sck <= ~spi_sck;
            halves_r <= halves_r + 5'd1;
            if (!spi_sck) begin
               shift_r <= {shift_r[6:0], miso_s};
            end else begin
               spi_mosi <= shift_r[7];
            end
            if (halves_r == `I2CMC_SPI_HALVES - 5'd1) begin
               // Clock ends low and stays there
               spi_act_r <= 1'b0;
               buf_r <= shift_r;
            end
         end
      end
   end
endmodule // i2cmc_top
`default_nettype wire

/* File: test/i2cmc_bus_model.sv */
// Open-drain I2C bus with pull-ups, other masters, and a small SPI slave.
// Assumes the bench decides when another master pulls a line low.
`timescale 1ns/1ps
`default_nettype none
module i2cmc_bus_model (
   // Reset
   input wire logic arst_n,
   // Master enables and other masters
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic pull_scl,
   input wire logic pull_sda,
   // SPI slave
   input wire logic spi_sck,
   input wire logic [7:0] reply,
   output logic spi_miso,
   // Resolved lines
   output logic scl,
   output logic sda
);
   logic [2:0] bit_r;
   // Pull-ups: a released line reads high
   assign scl = !(scl_oe || pull_scl);
   assign sda = !(sda_oe || pull_sda);
   // Shift on falling clock so data is steady at the rising sample
   always @(negedge spi_sck or negedge arst_n)
      if (!arst_n) bit_r <= 3'h0;
      else bit_r <= bit_r + 3'h1;
   assign spi_miso = reply[~bit_r];
endmodule // i2cmc_bus_model
`default_nettype wire

/* File: test/i2cmc_monitor.sv */
// Port checks for the I2C master, collision and baud rate block.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module i2cmc_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   // Lines
   input wire logic scl_out,
   input wire logic sda_out,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic spi_sck,
   input wire logic spi_mosi
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   sequence rs_drive_s;
      $rose(sda_oe) && !scl_oe;
   endsequence
   sequence stop_release_s;
      $fell(scl_oe) && sda_oe;
   endsequence
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   read_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o)
      else $error("read data moved without ack");
   upper_zero_a: assert property (wb_dat_o[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   open_drain_a: assert property (!scl_out && !sda_out)
      else $error("line output not low");
   rs_finish_a: assert property (rs_drive_s |-> sda_oe throughout (!scl_oe[*4] ##[1:600] scl_oe))
      else $error("repeated start did not end with clock low");
   stop_hold_a: assert property (stop_release_s |-> sda_oe[*3] ##[1:600] !sda_oe)
      else $error("stop did not release data");
   mosi_stable_a: assert property ($changed(spi_mosi) |-> !spi_sck)
      else $error("mosi moved while clock high");
   sck_high_a: assert property ($rose(spi_sck) |-> spi_sck[*6])
      else $error("sck high phase too short");
   sck_low_a: assert property ($fell(spi_sck) |-> !spi_sck[*6])
      else $error("sck low phase too short");
endmodule // i2cmc_monitor
bind i2cmc_top i2cmc_monitor u_mon (
   .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .scl_out(scl_out), .sda_out(sda_out),
   .scl_oe(scl_oe), .sda_oe(sda_oe), .spi_sck(spi_sck), .spi_mosi(spi_mosi)
);
`default_nettype wire

/* File: test/i2cmc_top_tb.sv */
// Self-checking bench for the I2C master collision and baud rate block.
// Assumes the bus model for the far side and the bound monitor.
`timescale 1ns/1ps
`default_nettype none
`include "i2cmc_defs.vh"
module i2cmc_top_tb;
   logic clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic scl, sda, scl_out, scl_oe, sda_out, sda_oe, spi_sck, spi_mosi, spi_miso;
   logic pull_scl, pull_sda;
   int mismatches, n_checks;
   localparam logic [7:0] RELOAD = 8'h03;
   localparam logic [7:0] REPLY = 8'h3C;
   localparam logic [7:0] TXB = 8'hA5;
   i2cmc_top DUT (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_in(scl), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .irq(irq));
   i2cmc_bus_model u_bus (.arst_n(arst_n), .scl_oe(scl_oe), .sda_oe(sda_oe),
      .pull_scl(pull_scl), .pull_sda(pull_sda), .spi_sck(spi_sck), .reply(REPLY),
      .spi_miso(spi_miso), .scl(scl), .sda(sda));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
         output logic [7:0] q);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h00_0000, d};
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(a, 1'b1, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] q;
      wb(a, 1'b0, 8'h00, q);
      chk(q, exp, what);
   endtask
   task automatic wait_idle;
      logic [7:0] q;
      do wb(`I2CMC_ADR_CTRL, 1'b0, 8'h00, q); while (q[1:0] !== 2'b00 || q[7] !== 1'b0);
   endtask
   // Another master pulls a line lag cycles after the clock release, or 3 plus lag cycles after the control write
   task automatic i2c_run(input logic [7:0] ctl, input logic rel, input int lag,
         input logic ps, input logic pd, input logic [7:0] st, input logic [1:0] oe);
      wr(`I2CMC_ADR_CTRL, ctl);
      repeat (3) @(posedge clk);
      if (rel) while (scl_oe !== 1'b0) @(posedge clk);
      repeat (lag) @(posedge clk);
      pull_scl <= ps;
      pull_sda <= pd;
      wait_idle;
      chk({scl_oe, sda_oe}, oe, "line drive");
      chk(irq, st != 8'h00, "irq level");
      rdc(`I2CMC_ADR_STAT, st, "status");
      chk(irq, 1'b0, "irq after clear");
      pull_scl <= 1'b0;
      pull_sda <= 1'b0;
      @(posedge clk);
   endtask
   task automatic regs;
      rdc(`I2CMC_ADR_RELOAD, 8'h09, "reload reset");
      rdc(`I2CMC_ADR_CTRL, 8'h00, "ctrl reset");
      rdc(`I2CMC_ADR_STAT, 8'h00, "status reset");
      wr(8'h14, 8'h5A);
      rdc(8'h14, 8'h00, "unmapped");
      wr(`I2CMC_ADR_RELOAD, RELOAD);
      rdc(`I2CMC_ADR_RELOAD, RELOAD, "reload");
      wr(`I2CMC_ADR_MASK, 8'h0F);
      rdc(`I2CMC_ADR_MASK, 8'h0F, "mask");
   endtask
   task automatic stop_ok;
      i2c_run(8'h0A, 1'b0, 0, 1'b0, 1'b0, 8'h02, 2'b00);
   endtask
   task automatic rs_ok;
      i2c_run(8'h09, 1'b0, 0, 1'b0, 1'b0, 8'h00, 2'b11);
   endtask
   task automatic rs_early;
      i2c_run(8'h09, 1'b1, 4, 1'b0, 1'b1, 8'h00, 2'b11);
   endtask
   task automatic rs_c1;
      i2c_run(8'h09, 1'b0, 3, 1'b0, 1'b1, 8'h01, 2'b00);
   endtask
   task automatic rs_c2;
      i2c_run(8'h09, 1'b1, 4, 1'b1, 1'b0, 8'h01, 2'b00);
   endtask
   task automatic stop_c1;
      i2c_run(8'h0A, 1'b1, 4, 1'b0, 1'b1, 8'h01, 2'b00);
   endtask
   task automatic stop_c2;
      i2c_run(8'h0A, 1'b1, 4, 1'b1, 1'b0, 8'h01, 2'b00);
   endtask
   task automatic spi_xfer;
      time t0;
      wr(`I2CMC_ADR_CTRL, 8'h0C);
      wr(`I2CMC_ADR_BUF, TXB);
      for (int i = 7; i >= 0; i--) begin
         @(posedge spi_sck);
         chk(spi_mosi, TXB[i], "mosi bit");
         if (i == 6) chk((($time - t0) / 100) inside {[4*(RELOAD+1):4*(RELOAD+1)+2]},
            1'b1, "sck period");
         t0 = $time;
         // Dropped because the byte is still running
         if (i == 7) wr(`I2CMC_ADR_BUF, 8'hFF);
      end
      wait_idle;
      rdc(`I2CMC_ADR_STAT, 8'h0C, "spi status");
      rdc(`I2CMC_ADR_BUF, REPLY, "received byte");
      repeat (20) @(posedge clk);
      chk(spi_sck, 1'b0, "sck held");
   endtask
   task automatic buf_i2c;
      wr(`I2CMC_ADR_CTRL, 8'h08);
      wr(`I2CMC_ADR_BUF, 8'h5A);
      rdc(`I2CMC_ADR_CTRL, 8'h88, "generator busy");
      wait_idle;
      rdc(`I2CMC_ADR_BUF, 8'h5A, "stored byte");
   endtask
   task automatic irq_mask;
      wr(`I2CMC_ADR_MASK, 8'h00);
      wr(`I2CMC_ADR_CTRL, 8'h0A);
      wait_idle;
      chk(irq, 1'b0, "masked irq");
      wr(`I2CMC_ADR_MASK, 8'h02);
      chk(irq, 1'b1, "unmasked irq");
      rdc(`I2CMC_ADR_STAT, 8'h02, "stop done");
      chk(irq, 1'b0, "irq cleared");
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      end_of_test;
   end
   initial begin
      {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, pull_scl, pull_sda} = 6'h00;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0000_0000;
      wb_sel_i = 4'h1;
      mismatches = 0;
      n_checks = 0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      regs;
      stop_ok;
      rs_ok;
      rs_early;
      rs_c1;
      rs_c2;
      stop_c1;
      stop_c2;
      spi_xfer;
      buf_i2c;
      irq_mask;
      end_of_test;
   end
endmodule // i2cmc_top_tb
`default_nettype wire
